// ===== logic/fspr_pkg.sv
// Purpose: shared constants of the flash status and protection registers
// Assumes: single SPI, mode 0, one MCLK domain
// Notes: bit positions index the 8-bit status bytes
package fspr_pkg;
  // ==========================================================
  // documented opcodes
  localparam logic [7:0] OP_WRITE_ENABLE = 8'h06;
  localparam logic [7:0] OP_VOL_WRITE_ENABLE = 8'h50;
  localparam logic [7:0] OP_WRITE_DISABLE = 8'h04;
  localparam logic [7:0] OP_WRITE_STATUS_ONE = 8'h01;
  localparam logic [7:0] OP_WRITE_STATUS_TWO = 8'h31;
  localparam logic [7:0] OP_WRITE_STATUS_THREE = 8'h11;
  localparam logic [7:0] OP_SUSPEND = 8'h75;
  localparam logic [7:0] OP_RESUME = 8'h7a;
  // ==========================================================
  // field positions
  localparam int SR1_BUSY = 0;
  localparam int SR1_LATCH = 1;
  localparam int SR1_LOCK_LO = 7;
  localparam int SR2_LOCK_HI = 0;
  localparam int SR2_QUAD = 1;
  localparam int SR2_PROG_SUS = 2;
  localparam int SR2_SEC_LSB = 3;
  localparam int SR2_COMPL = 6;
  localparam int SR2_ERASE_SUS = 7;
  localparam int SR3_SCHEME = 2;
  localparam int SR3_FREQ = 4;
  localparam int SR3_DRV_LSB = 5;
  localparam int SR3_PIN_SEL = 7;
  // ==========================================================
  // writable masks and defaults
  localparam logic [7:0] SR1_CFG_MASK = 8'hfc;
  localparam logic [7:0] SR2_CFG_MASK = 8'h43;
  localparam logic [7:0] SR2_SEC_MASK = 8'h38;
  localparam logic [7:0] SR3_CFG_MASK = 8'hf5;
  localparam logic [7:0] SR1_DEFAULT = 8'h00;
  localparam logic [7:0] SR2_DEFAULT = 8'h00;
  localparam logic [7:0] SR3_DEFAULT = 8'h70;
  // ==========================================================
  // timing
  localparam int CLK_PERIOD_NS = 4;
endpackage

// ===== logic/fspr_sync.sv
// Purpose: two-flop synchroniser for pin inputs
// Assumes: inputs asynchronous to MCLK
// Notes: only the second stage is visible
`timescale 1ns/100ps
`default_nettype none
module fspr_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] RESET_VAL = '0
) (
  // clock and reset
  input wire logic MCLK,
  input wire logic RST_N,
  // data
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);
  logic [W-1:0] stage1;
  always_ff @(posedge MCLK)
  begin
    if (!RST_N)
    begin
      stage1 <= RESET_VAL;
      dout <= RESET_VAL;
    end
    else
    begin
      stage1 <= din;
      dout <= stage1;
    end
  end
endmodule // fspr_sync
`default_nettype wire

// ===== logic/fspr_busy_timer.sv
// Purpose: embedded operation timer behind the busy flag
// Assumes: start, hold and abort come from MCLK logic
// Notes: hold freezes the count while an operation is suspended
`timescale 1ns/100ps
`default_nettype none
module fspr_busy_timer #(
  parameter int CNT_W = 16
) (
  // clock and reset
  input wire logic MCLK,
  input wire logic RST_N,
  // control
  input wire logic start,
  input wire logic [CNT_W-1:0] cycles,
  input wire logic hold,
  input wire logic abort,
  // status
  output logic running,
  output logic done
);
  logic [CNT_W-1:0] cnt;
  logic [CNT_W-1:0] next_cnt;
  logic next_running;
  logic next_done;
  always_comb
  begin
    next_cnt = cnt;
    next_done = 1'b0;
    if (abort)
      next_cnt = '0;
    else if (start)
      next_cnt = cycles;
    else if (cnt != '0 && !hold)
    begin
      next_cnt = cnt - 1'b1;
      next_done = (cnt == {{(CNT_W-1){1'b0}}, 1'b1});
    end
    next_running = (next_cnt != '0) && !hold;
  end
  always_ff @(posedge MCLK)
  begin
    if (!RST_N)
    begin
      cnt <= '0;
      running <= 1'b0;
      done <= 1'b0;
    end
    else
    begin
      cnt <= next_cnt;
      running <= next_running;
      done <= next_done;
    end
  end
endmodule // fspr_busy_timer
`default_nettype wire

// ===== logic/fspr_status_regs.sv
// Purpose: status, configuration and protection registers of a serial flash
// Assumes: SPI mode 0 on pins sampled by MCLK; RST_N stands for a power cycle
// Notes: array decoding and block lock commands live elsewhere
`timescale 1ns/100ps
`default_nettype none
module fspr_status_regs #(
  parameter logic [7:0] OP_PROGRAM = 8'h02,
  parameter logic [7:0] OP_ERASE_SECTOR = 8'h20,
  parameter logic [7:0] OP_ERASE_BLOCK = 8'hd8,
  parameter logic [7:0] OP_ERASE_CHIP = 8'hc7,
  parameter logic [7:0] OP_RESET_ENABLE = 8'h66,
  parameter logic [7:0] OP_RESET = 8'h99,
  parameter logic [7:0] OP_READ_ONE = 8'h05,
  parameter logic [7:0] OP_READ_TWO = 8'h35,
  parameter logic [7:0] OP_READ_THREE = 8'h15,
  parameter int T_STATUS_WRITE_NS = 1000,
  parameter int T_PROGRAM_NS = 2000,
  parameter int T_ERASE_NS = 4000,
  parameter int CNT_W = 16
) (
  // clock and reset
  input wire logic MCLK,
  input wire logic RST_N,
  // serial link
  input wire logic SCLK,
  input wire logic CS_N,
  input wire logic DI,
  output logic SO,
  output logic SO_OE,
  // shared control pins
  input wire logic WP_N,
  input wire logic HOLD_N,
  // protection view
  output logic [2:0] RANGE_BITS,
  output logic FROM_BOTTOM,
  output logic SECTOR_UNITS,
  output logic COMPLEMENT,
  output logic BLOCK_SCHEME,
  output logic BLOCK_LOCKS_SET,
  output logic [2:0] SECURITY_LOCK,
  // pin and pad configuration, and busy flag
  output logic QUAD_MODE,
  output logic HOLD_ACTIVE,
  output logic [1:0] DRIVE_STRENGTH,
  output logic HIGH_FREQ,
  output logic BUSY
);
  // ==========================================================
  // timing and checks
  localparam int SW_CYC = (T_STATUS_WRITE_NS + fspr_pkg::CLK_PERIOD_NS - 1)
    / fspr_pkg::CLK_PERIOD_NS;
  localparam int PP_CYC = (T_PROGRAM_NS + fspr_pkg::CLK_PERIOD_NS - 1)
    / fspr_pkg::CLK_PERIOD_NS;
  localparam int ER_CYC = (T_ERASE_NS + fspr_pkg::CLK_PERIOD_NS - 1)
    / fspr_pkg::CLK_PERIOD_NS;
  if (SW_CYC < 1 || PP_CYC < 1 || ER_CYC < 1 || SW_CYC >= 2**CNT_W
      || PP_CYC >= 2**CNT_W || ER_CYC >= 2**CNT_W)
  begin : g_bad_time
    $error("busy times do not fit the timer");
  end
  // ==========================================================
  // pin synchronisers
  logic [4:0] pin_s;
  logic sclk_s, cs_n_s, di_s, wp_n_s, hold_n_s;
  fspr_sync #(.W(5), .RESET_VAL(5'h1a)) u_sync (
    .MCLK(MCLK),
    .RST_N(RST_N),
    .din({HOLD_N, WP_N, DI, CS_N, SCLK}),
    .dout(pin_s)
  );
  assign {hold_n_s, wp_n_s, di_s, cs_n_s, sclk_s} = pin_s;
  // ==========================================================
  // state
  logic sclk_q, cs_q;
  logic [7:0] shift, cmd, d1, d2;
  logic [2:0] bit_cnt;
  logic [1:0] byte_cnt;
  logic [7:0] nv_sr1, nv_sr2, nv_sr3, vol_sr1, vol_sr2, vol_sr3;
  logic [2:0] nv_lock;
  logic write_latch, vol_wren, sus_erase, sus_prog, rst_armed, blk_locks;
  logic op_status, op_erase, so_q, so_oe_q;
  logic [7:0] next_shift, next_cmd, next_d1, next_d2;
  logic [2:0] next_bit_cnt;
  logic [1:0] next_byte_cnt;
  logic [7:0] next_nv_sr1, next_nv_sr2, next_nv_sr3;
  logic [7:0] next_vol_sr1, next_vol_sr2, next_vol_sr3;
  logic [2:0] next_nv_lock;
  logic next_wel, next_vol_wren, next_sus_erase, next_sus_prog;
  logic next_rst_armed, next_blk_locks, next_op_status, next_op_erase;
  logic next_so, next_so_oe;
  // decoded terms
  logic sclk_rise, sclk_fall, cs_rise, exec, pin_hold, pin_reset;
  logic wp_low, sr_locked, reading, soft_reset;
  logic [7:0] sr1, sr2, sr3, rd_byte, data1, data2;
  logic has2;
  // timer
  logic t_start, t_abort, t_running, t_done;
  logic [CNT_W-1:0] t_cycles;
  fspr_busy_timer #(.CNT_W(CNT_W)) u_timer (
    .MCLK(MCLK),
    .RST_N(RST_N),
    .start(t_start),
    .cycles(t_cycles),
    .hold(next_sus_erase | next_sus_prog),
    .abort(t_abort),
    .running(t_running),
    .done(t_done)
  );
  // ==========================================================
  // status views
  assign sr1 = {vol_sr1[7:2], write_latch, t_running};
  assign sr2 = {sus_erase, vol_sr2[fspr_pkg::SR2_COMPL], nv_lock, sus_prog,
    vol_sr2[1:0]};
  assign sr3 = vol_sr3 & fspr_pkg::SR3_CFG_MASK;
  // ==========================================================
  // next state
  always_comb
  begin
    next_shift = shift;
    next_cmd = cmd;
    next_d1 = d1;
    next_d2 = d2;
    next_bit_cnt = bit_cnt;
    next_byte_cnt = byte_cnt;
    next_nv_sr1 = nv_sr1;
    next_nv_sr2 = nv_sr2;
    next_nv_sr3 = nv_sr3;
    next_vol_sr1 = vol_sr1;
    next_vol_sr2 = vol_sr2;
    next_vol_sr3 = vol_sr3;
    next_nv_lock = nv_lock;
    next_wel = write_latch;
    next_vol_wren = vol_wren;
    next_sus_erase = sus_erase;
    next_sus_prog = sus_prog;
    next_rst_armed = rst_armed;
    next_blk_locks = blk_locks;
    next_op_status = op_status;
    next_op_erase = op_erase;
    next_so = so_q;
    t_start = 1'b0;
    t_abort = 1'b0;
    t_cycles = '0;
    soft_reset = 1'b0;
    sclk_rise = sclk_s & ~sclk_q;
    sclk_fall = ~sclk_s & sclk_q;
    cs_rise = cs_n_s & ~cs_q;
    exec = cs_rise && bit_cnt == 3'h0 && byte_cnt != 2'h0;
    pin_hold = ~vol_sr2[fspr_pkg::SR2_QUAD] & ~vol_sr3[fspr_pkg::SR3_PIN_SEL]
      & ~hold_n_s;
    pin_reset = ~vol_sr2[fspr_pkg::SR2_QUAD] & vol_sr3[fspr_pkg::SR3_PIN_SEL]
      & ~hold_n_s;
    wp_low = ~vol_sr2[fspr_pkg::SR2_QUAD] & ~wp_n_s;
    sr_locked = vol_sr2[fspr_pkg::SR2_LOCK_HI] | (vol_sr1[fspr_pkg::SR1_LOCK_LO]
      & wp_low);
    reading = byte_cnt != 2'h0 && (cmd == OP_READ_ONE || cmd == OP_READ_TWO
      || cmd == OP_READ_THREE);
    rd_byte = cmd == OP_READ_ONE ? sr1 : (cmd == OP_READ_TWO ? sr2 : sr3);
    has2 = byte_cnt == 2'h3;
    data1 = 8'h00;
    data2 = 8'h00;
    // serial shifter
    if (cs_n_s)
    begin
      next_bit_cnt = 3'h0;
      next_byte_cnt = 2'h0;
    end
    else if (sclk_rise && !pin_hold)
    begin
      next_shift = {shift[6:0], di_s};
      next_bit_cnt = bit_cnt + 3'h1;
      if (bit_cnt == 3'h7)
      begin
        if (byte_cnt == 2'h0)
          next_cmd = {shift[6:0], di_s};
        else if (byte_cnt == 2'h1)
          next_d1 = {shift[6:0], di_s};
        else if (byte_cnt == 2'h2)
          next_d2 = {shift[6:0], di_s};
        if (byte_cnt != 2'h3)
          next_byte_cnt = byte_cnt + 2'h1;
      end
    end
    else if (sclk_fall && !pin_hold && reading)
      next_so = rd_byte[~bit_cnt];
    next_so_oe = ~cs_n_s & reading;
    // instruction execution
    if (exec && (!t_running || cmd == fspr_pkg::OP_SUSPEND))
    begin
      next_rst_armed = (cmd == OP_RESET_ENABLE);
      if (cmd == fspr_pkg::OP_WRITE_ENABLE)
        next_wel = 1'b1;
      else if (cmd == fspr_pkg::OP_VOL_WRITE_ENABLE)
        next_vol_wren = 1'b1;
      else if (cmd == fspr_pkg::OP_WRITE_DISABLE)
      begin
        next_wel = 1'b0;
        next_vol_wren = 1'b0;
      end
      else if ((cmd == fspr_pkg::OP_WRITE_STATUS_ONE
          || cmd == fspr_pkg::OP_WRITE_STATUS_TWO
          || cmd == fspr_pkg::OP_WRITE_STATUS_THREE)
          && byte_cnt >= 2'h2 && (write_latch || vol_wren))
      begin
        next_wel = 1'b0;
        next_vol_wren = 1'b0;
        data1 = d1;
        data2 = d2;
        if (!sr_locked)
        begin
          if (cmd == fspr_pkg::OP_WRITE_STATUS_ONE)
          begin
            next_vol_sr1 = (vol_sr1 & ~fspr_pkg::SR1_CFG_MASK)
              | (data1 & fspr_pkg::SR1_CFG_MASK);
            if (has2)
              next_vol_sr2 = (vol_sr2 & ~fspr_pkg::SR2_CFG_MASK)
                | (data2 & fspr_pkg::SR2_CFG_MASK);
          end
          else if (cmd == fspr_pkg::OP_WRITE_STATUS_TWO)
          begin
            next_vol_sr2 = (vol_sr2 & ~fspr_pkg::SR2_CFG_MASK)
              | (data1 & fspr_pkg::SR2_CFG_MASK);
            data2 = data1;
          end
          else
            next_vol_sr3 = (vol_sr3 & ~fspr_pkg::SR3_CFG_MASK)
              | (data1 & fspr_pkg::SR3_CFG_MASK);
          if (write_latch)
          begin
            next_nv_sr1 = next_vol_sr1;
            next_nv_sr2 = next_vol_sr2;
            next_nv_sr3 = next_vol_sr3;
            if (cmd != fspr_pkg::OP_WRITE_STATUS_THREE && (has2
                || cmd == fspr_pkg::OP_WRITE_STATUS_TWO))
              next_nv_lock = nv_lock | data2[fspr_pkg::SR2_SEC_LSB +: 3];
            t_start = 1'b1;
            t_cycles = CNT_W'(SW_CYC);
            next_op_status = 1'b1;
          end
          else
          begin
            next_nv_lock = nv_lock;
          end
        end
      end
      else if ((cmd == OP_PROGRAM || cmd == OP_ERASE_SECTOR
          || cmd == OP_ERASE_BLOCK || cmd == OP_ERASE_CHIP)
          && write_latch && !sus_erase && !sus_prog)
      begin
        next_wel = 1'b0;
        t_start = 1'b1;
        t_cycles = CNT_W'(cmd == OP_PROGRAM ? PP_CYC : ER_CYC);
        next_op_status = 1'b0;
        next_op_erase = (cmd != OP_PROGRAM);
      end
      else if (cmd == fspr_pkg::OP_SUSPEND && t_running && !op_status)
      begin
        next_sus_erase = op_erase;
        next_sus_prog = ~op_erase;
      end
      else if (cmd == fspr_pkg::OP_RESUME)
      begin
        next_sus_erase = 1'b0;
        next_sus_prog = 1'b0;
      end
      else if (cmd == OP_RESET && rst_armed)
        soft_reset = 1'b1;
    end
    if (pin_reset && !t_running)
      soft_reset = 1'b1;
    if (soft_reset)
    begin
      if (nv_sr2[fspr_pkg::SR2_LOCK_HI] && !nv_sr1[fspr_pkg::SR1_LOCK_LO])
      begin
        next_nv_sr2[fspr_pkg::SR2_LOCK_HI] = 1'b0;
      end
      next_vol_sr1 = next_nv_sr1;
      next_vol_sr2 = next_nv_sr2;
      next_vol_sr3 = next_nv_sr3;
      next_wel = 1'b0;
      next_vol_wren = 1'b0;
      next_sus_erase = 1'b0;
      next_sus_prog = 1'b0;
      next_rst_armed = 1'b0;
      next_blk_locks = 1'b1;
      t_abort = 1'b1;
    end
  end
  // ==========================================================
  // registers
  always_ff @(posedge MCLK)
  begin
    if (!RST_N)
    begin
      sclk_q <= 1'b0;
      cs_q <= 1'b1;
      shift <= 8'h00;
      cmd <= 8'h00;
      d1 <= 8'h00;
      d2 <= 8'h00;
      bit_cnt <= 3'h0;
      byte_cnt <= 2'h0;
      nv_sr1 <= fspr_pkg::SR1_DEFAULT;
      nv_sr2 <= fspr_pkg::SR2_DEFAULT;
      nv_sr3 <= fspr_pkg::SR3_DEFAULT;
      vol_sr1 <= fspr_pkg::SR1_DEFAULT;
      vol_sr2 <= fspr_pkg::SR2_DEFAULT;
      vol_sr3 <= fspr_pkg::SR3_DEFAULT;
      nv_lock <= 3'h0;
      write_latch <= 1'b0;
      vol_wren <= 1'b0;
      sus_erase <= 1'b0;
      sus_prog <= 1'b0;
      rst_armed <= 1'b0;
      blk_locks <= 1'b1;
      op_status <= 1'b0;
      op_erase <= 1'b0;
      so_q <= 1'b0;
      so_oe_q <= 1'b0;
    end
    else
    begin
      sclk_q <= sclk_s;
      cs_q <= cs_n_s;
      shift <= next_shift;
      cmd <= next_cmd;
      d1 <= next_d1;
      d2 <= next_d2;
      bit_cnt <= next_bit_cnt;
      byte_cnt <= next_byte_cnt;
      nv_sr1 <= next_nv_sr1;
      nv_sr2 <= next_nv_sr2;
      nv_sr3 <= next_nv_sr3;
      vol_sr1 <= next_vol_sr1;
      vol_sr2 <= next_vol_sr2;
      vol_sr3 <= next_vol_sr3;
      nv_lock <= next_nv_lock;
      write_latch <= next_wel;
      vol_wren <= next_vol_wren;
      sus_erase <= next_sus_erase;
      sus_prog <= next_sus_prog;
      rst_armed <= next_rst_armed;
      blk_locks <= next_blk_locks;
      op_status <= next_op_status;
      op_erase <= next_op_erase;
      so_q <= next_so;
      so_oe_q <= next_so_oe;
    end
  end
  // ==========================================================
  // outputs
  assign SO = so_q;
  assign SO_OE = so_oe_q;
  always_ff @(posedge MCLK)
  begin
    if (!RST_N)
    begin
      RANGE_BITS <= 3'h0;
      FROM_BOTTOM <= 1'b0;
      SECTOR_UNITS <= 1'b0;
      COMPLEMENT <= 1'b0;
      BLOCK_SCHEME <= 1'b0;
      BLOCK_LOCKS_SET <= 1'b1;
      SECURITY_LOCK <= 3'h0;
      QUAD_MODE <= 1'b0;
      HOLD_ACTIVE <= 1'b0;
      DRIVE_STRENGTH <= 2'h3;
      HIGH_FREQ <= 1'b1;
      BUSY <= 1'b0;
    end
    else
    begin
      RANGE_BITS <= vol_sr1[4:2];
      FROM_BOTTOM <= vol_sr1[5];
      SECTOR_UNITS <= vol_sr1[6];
      COMPLEMENT <= vol_sr2[fspr_pkg::SR2_COMPL];
      BLOCK_SCHEME <= vol_sr3[fspr_pkg::SR3_SCHEME];
      BLOCK_LOCKS_SET <= blk_locks;
      SECURITY_LOCK <= nv_lock;
      QUAD_MODE <= vol_sr2[fspr_pkg::SR2_QUAD];
      HOLD_ACTIVE <= pin_hold;
      DRIVE_STRENGTH <= vol_sr3[fspr_pkg::SR3_DRV_LSB +: 2];
      HIGH_FREQ <= vol_sr3[fspr_pkg::SR3_FREQ];
      BUSY <= t_running;
    end
  end
  // ==========================================================
  // checks
  chk_busy_ignores: assert property (@(posedge MCLK) disable iff (!RST_N)
    exec && t_running && cmd == fspr_pkg::OP_WRITE_ENABLE |=> $stable(write_latch))
    else $error("write enable taken while busy");
  chk_busy_done: assert property (@(posedge MCLK) disable iff (!RST_N)
    t_done |-> !t_running ##1 !BUSY)
    else $error("busy stays after completion");
  chk_latch_set: assert property (@(posedge MCLK) disable iff (!RST_N)
    exec && !t_running && cmd == fspr_pkg::OP_WRITE_ENABLE && !soft_reset
    |=> write_latch ##1 sr1[fspr_pkg::SR1_LATCH])
    else $error("write enable did not set latch");
  chk_latch_clear: assert property (@(posedge MCLK) disable iff (!RST_N)
    exec && !t_running && (cmd == fspr_pkg::OP_WRITE_DISABLE
    || (!sus_erase && !sus_prog && (cmd == OP_PROGRAM || cmd == OP_ERASE_SECTOR
    || cmd == OP_ERASE_BLOCK || cmd == OP_ERASE_CHIP))) |=> !write_latch)
    else $error("latch not cleared");
  chk_soft_write: assert property (@(posedge MCLK) disable iff (!RST_N)
    exec && !t_running && write_latch && !sr_locked && byte_cnt == 2'h2
    && cmd == fspr_pkg::OP_WRITE_STATUS_ONE |=> (nv_sr1 & fspr_pkg::SR1_CFG_MASK)
    == ($past(d1) & fspr_pkg::SR1_CFG_MASK) ##1 BUSY)
    else $error("software mode write lost");
  chk_hw_protect: assert property (@(posedge MCLK) disable iff (!RST_N)
    exec && !vol_sr2[fspr_pkg::SR2_LOCK_HI] && vol_sr1[fspr_pkg::SR1_LOCK_LO]
    && wp_low && !soft_reset |=> $stable(vol_sr1) && $stable(vol_sr2))
    else $error("write passed with pin low");
  chk_lockdown: assert property (@(posedge MCLK) disable iff (!RST_N)
    exec && vol_sr2[fspr_pkg::SR2_LOCK_HI] && !soft_reset
    |=> $stable(nv_sr1) && $stable(nv_sr3) && $stable(nv_lock))
    else $error("write passed under lock-down");
  chk_volatile_only: assert property (@(posedge MCLK) disable iff (!RST_N)
    exec && !write_latch && vol_wren && !t_running && !soft_reset |=> $stable(nv_sr1)
    && $stable(nv_sr2) && $stable(nv_lock))
    else $error("volatile write reached non-volatile bits");
  chk_flags_kept: assert property (@(posedge MCLK) disable iff (!RST_N)
    exec && cmd == fspr_pkg::OP_WRITE_STATUS_TWO && !soft_reset
    |=> $stable(sus_erase) && $stable(sus_prog))
    else $error("status write touched suspend flags");
  chk_otp_sticky: assert property (@(posedge MCLK) disable iff (!RST_N)
    1'b1 |=> (nv_lock & $past(nv_lock)) == $past(nv_lock))
    else $error("security lock bit cleared");
  chk_suspend_stops: assert property (@(posedge MCLK) disable iff (!RST_N)
    $rose(sus_erase) |-> !t_running [*3])
    else $error("busy while suspended");
  cov_nv_write: cover property (@(posedge MCLK) disable iff (!RST_N)
    t_start && op_status == 1'b0 ##[1:300] t_done);
  cov_vol_write: cover property (@(posedge MCLK) disable iff (!RST_N)
    exec && vol_wren && !write_latch && !sr_locked);
  cov_suspend: cover property (@(posedge MCLK) disable iff (!RST_N)
    $rose(sus_prog) ##[1:1000] $fell(sus_prog));
  cov_read: cover property (@(posedge MCLK) disable iff (!RST_N)
    $rose(SO_OE));
endmodule // fspr_status_regs
`default_nettype wire

// ===== verif/fspr_host.sv
// Purpose: spi host model issuing flash commands
// Assumes: mode 0, 125 ns serial clock
// Notes: serial clock stands low and data in flips between frames
`timescale 1ns/100ps
`default_nettype none
module fspr_host (
  // serial link
  output logic SCLK,
  output logic CS_N,
  output logic DI,
  input wire logic SO
);
  initial
  begin
    SCLK = 1'b0;
    CS_N = 1'b1;
    DI = 1'b0;
  end
  // ==========================================================
  // frame of n bits, msb first; rd keeps reply bits 8 to 15
  task automatic xfer(input logic [31:0] w, input int n, output logic [7:0] rd);
    rd = 8'h00;
    CS_N = 1'b0;
    for (int i = 0; i < n; i++)
    begin
      DI = w[31-i];
      #62.5 SCLK = 1'b1;
      if (i >= 8 && i < 16) rd = {rd[6:0], SO};
      #62.5 SCLK = 1'b0;
    end
    #62.5 CS_N = 1'b1;
    DI = ~DI;
    #250;
  endtask
endmodule // fspr_host
`default_nettype wire

// ===== verif/flash_status_protect_regs_tb_top.sv
// Purpose: self-checking bench of the flash status registers
// Assumes: host model drives the serial link
// Notes: status write and erase times lengthened through parameters
`timescale 1ns/100ps
`default_nettype none
`define CHK(n, e, a) begin checks++; if ((a) !== (e)) begin miscompares++; \
  $display("MISMATCH %s exp %h got %h", n, e, a); end end
module flash_status_protect_regs_tb_top;
  typedef struct packed {logic [7:0] op, rop, d, rb; logic [9:0] o;} fspr_row_type;
  logic MCLK, RST_N, WP_N, HOLD_N, SCLK, CS_N, DI, SO, SO_OE, BUSY, BLOCK_LOCKS_SET;
  logic FROM_BOTTOM, SECTOR_UNITS, COMPLEMENT, BLOCK_SCHEME, HIGH_FREQ, QUAD_MODE, HOLD_ACTIVE;
  logic [2:0] RANGE_BITS, SECURITY_LOCK;
  logic [1:0] DRIVE_STRENGTH;
  logic [7:0] v;
  int miscompares = 0;
  int checks = 0;
  wire [9:0] cfg = {RANGE_BITS, FROM_BOTTOM, SECTOR_UNITS, COMPLEMENT, BLOCK_SCHEME,
    DRIVE_STRENGTH, HIGH_FREQ};
  wire [10:0] pins = {BUSY, QUAD_MODE, cfg[2:0], BLOCK_LOCKS_SET, SECURITY_LOCK, SO_OE,
    HOLD_ACTIVE};
  fspr_row_type rows [9] = '{{8'h01, 8'h05, 8'h1c, 8'h1c, 10'h387},
    {8'h01, 8'h05, 8'h60, 8'h60, 10'h067}, {8'h31, 8'h35, 8'h40, 8'h40, 10'h077},
    {8'h11, 8'h15, 8'h84, 8'h84, 10'h078}, {8'h11, 8'h15, 8'h30, 8'h30, 10'h073},
    {8'h11, 8'h15, 8'h40, 8'h40, 10'h074}, {8'h11, 8'h15, 8'h70, 8'h70, 10'h077},
    {8'h01, 8'h05, 8'h00, 8'h00, 10'h017}, {8'h31, 8'h35, 8'h00, 8'h00, 10'h007}};
  fspr_status_regs #(.T_STATUS_WRITE_NS(6000), .T_ERASE_NS(12000)) fspr_status_regs_i (
    .MCLK(MCLK), .RST_N(RST_N), .SCLK(SCLK), .CS_N(CS_N), .DI(DI), .SO(SO), .SO_OE(SO_OE),
    .WP_N(WP_N), .HOLD_N(HOLD_N), .RANGE_BITS(RANGE_BITS), .FROM_BOTTOM(FROM_BOTTOM),
    .SECTOR_UNITS(SECTOR_UNITS), .COMPLEMENT(COMPLEMENT), .BLOCK_SCHEME(BLOCK_SCHEME),
    .BLOCK_LOCKS_SET(BLOCK_LOCKS_SET), .SECURITY_LOCK(SECURITY_LOCK), .QUAD_MODE(QUAD_MODE),
    .HOLD_ACTIVE(HOLD_ACTIVE), .DRIVE_STRENGTH(DRIVE_STRENGTH), .HIGH_FREQ(HIGH_FREQ),
    .BUSY(BUSY));
  // undriven serial output shows the inverse of its last bit
  fspr_host fspr_host_i (.SCLK(SCLK), .CS_N(CS_N), .DI(DI), .SO(SO_OE ? SO : ~SO));
  // ==========================================================
  // command helpers
  task automatic cmd(input logic [7:0] op);
    fspr_host_i.xfer({op, 24'h0}, 8, v);
  endtask
  task automatic rd(input logic [7:0] op);
    fspr_host_i.xfer({op, 24'h0}, 16, v);
    if (op == 8'h15) v = v & 8'hf5;
  endtask
  task automatic idle;
    repeat (8) @(negedge MCLK);
    for (int k = 0; k < 5000 && BUSY !== 1'b0; k++) @(negedge MCLK);
    `CHK("idle", 1'b0, BUSY)
  endtask
  task automatic wr(input logic [7:0] op, input logic [7:0] d);
    cmd(8'h06);
    fspr_host_i.xfer({op, d, 16'h0}, 16, v);
    idle();
  endtask
  task automatic results;
    if (miscompares == 0 && checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  // ==========================================================
  // clock, watchdog and sequence
  initial
  begin
    MCLK = 1'b0;
    forever #2 MCLK = ~MCLK;
  end
  initial
  begin
    #400000;
    miscompares++;
    results();
  end
  initial
  begin
    RST_N = 1'b0;
    WP_N = 1'b1;
    HOLD_N = 1'b1;
    repeat (8) @(negedge MCLK);
    RST_N = 1'b1;
    repeat (4) @(negedge MCLK);
    `CHK("pins", 11'h1e0, pins)
    rd(8'h15);
    `CHK("sr3", 8'h70, v)
    cmd(8'h06);
    rd(8'h05);
    `CHK("latch", 8'h02, v)
    cmd(8'h04);
    rd(8'h05);
    `CHK("unlatch", 8'h00, v)
    fspr_host_i.xfer(32'h011c0000, 16, v);
    rd(8'h05);
    `CHK("no enable", 8'h00, v)
    foreach (rows[i])
    begin
      wr(rows[i].op, rows[i].d);
      rd(rows[i].rop);
      `CHK("row read", rows[i].rb, v)
      `CHK("row pins", rows[i].o, cfg)
    end
    cmd(8'h06);
    fspr_host_i.xfer(32'h010c0000, 16, v);
    cmd(8'h06);
    rd(8'h05);
    `CHK("busy read", 8'h0d, v)
    idle();
    rd(8'h05);
    `CHK("busy done", 8'h0c, v)
    wr(8'h01, 8'h80);
    WP_N = 1'b0;
    wr(8'h01, 8'h9c);
    rd(8'h05);
    `CHK("wp low", 8'h80, v)
    @(negedge MCLK);
    WP_N = 1'b1;
    wr(8'h01, 8'h04);
    rd(8'h05);
    `CHK("wp high", 8'h04, v)
    wr(8'h31, 8'h38);
    `CHK("otp", 3'h7, SECURITY_LOCK)
    cmd(8'h50);
    fspr_host_i.xfer(32'h31400000, 16, v);
    rd(8'h35);
    `CHK("volatile", 8'h78, v)
    wr(8'h31, 8'h01);
    wr(8'h01, 8'h1c);
    rd(8'h05);
    `CHK("lockdown", 8'h04, v)
    cmd(8'h66);
    cmd(8'h99);
    idle();
    rd(8'h35);
    `CHK("soft reset", 8'h38, v)
    wr(8'h01, 8'h20);
    cmd(8'h06);
    fspr_host_i.xfer(32'h20000000, 32, v);
    cmd(8'h75);
    rd(8'h35);
    `CHK("suspended", 8'hb8, v)
    `CHK("suspend busy", 1'b0, BUSY)
    cmd(8'h7a);
    rd(8'h35);
    `CHK("resumed", 8'h38, v)
    idle();
    // shared pin as hold, then as reset
    @(negedge MCLK);
    HOLD_N = 1'b0;
    repeat (4) @(negedge MCLK);
    `CHK("hold pin", 1'b1, HOLD_ACTIVE)
    HOLD_N = 1'b1;
    wr(8'h11, 8'h80);
    cmd(8'h06);
    @(negedge MCLK);
    HOLD_N = 1'b0;
    repeat (4) @(negedge MCLK);
    `CHK("reset pin", 1'b0, HOLD_ACTIVE)
    HOLD_N = 1'b1;
    repeat (4) @(negedge MCLK);
    rd(8'h05);
    `CHK("reset pin latch", 8'h20, v)
    // quad mode frees both control pins
    wr(8'h31, 8'h02);
    wr(8'h01, 8'h80);
    WP_N = 1'b0;
    HOLD_N = 1'b0;
    cmd(8'h06);
    rd(8'h05);
    `CHK("quad latch", 8'h82, v)
    wr(8'h01, 8'h84);
    rd(8'h05);
    `CHK("quad wp", 8'h84, v)
    `CHK("quad pins", 2'h2, {QUAD_MODE, HOLD_ACTIVE})
    // second power cycle in mid-run
    @(negedge MCLK);
    WP_N = 1'b1;
    HOLD_N = 1'b1;
    RST_N = 1'b0;
    repeat (8) @(negedge MCLK);
    RST_N = 1'b1;
    repeat (4) @(negedge MCLK);
    `CHK("reset again", 11'h1e0, pins)
    rd(8'h05);
    `CHK("reset sr1", 8'h00, v)
    results();
  end
endmodule // flash_status_protect_regs_tb_top
`default_nettype wire
